// File: logic/pin_route_defines.svh
// Constants for the peripheral pin routing block: offsets, fields,
// reset values and the pin and function index maps.
// Assumes inclusion by bare name from files under logic/.
`ifndef PIN_ROUTE_DEFINES_SVH
`define PIN_ROUTE_DEFINES_SVH

// ************************************************************
// Sizes
// ************************************************************
`define ADDR_W          8
`define DATA_W          32
`define PIN_N           28
`define FN_N            17
`define IDX_W           5

// ************************************************************
// Register offsets and fields
// ************************************************************
`define OPT_OFFSET      8'h04
`define SEL_OFFSET      8'h08
`define SEL_WR_MASK     32'h0000_FFF0
`define SEL_RESET       16'h0000
`define IPE_BIT         1
`define IPE_POR_VALUE   1'h1
`define SEL_TOP         15

// Select bit positions
`define T2C3_SEL        15
`define T2C2_SEL        14
`define T2C1_SEL        13
`define T2C0_SEL        12
`define T1C1_SEL        11
`define T1C0_SEL        10
`define T0C1_SEL        9
`define T0C0_SEL        8
`define UART_SEL        7
`define SPI_SEL         6
`define I2C_SEL         5
`define CNT_SEL         4

// ************************************************************
// Pin indices
// ************************************************************
`define PA0 5'h00
`define PA1 5'h01
`define PA2 5'h02
`define PA3 5'h03
`define PB0 5'h04
`define PB1 5'h05
`define PB2 5'h06
`define PB3 5'h07
`define PB4 5'h08
`define PB5 5'h09
`define PB6 5'h0A
`define PB7 5'h0B
`define PC0 5'h0C
`define PC1 5'h0D
`define PC2 5'h0E
`define PC3 5'h0F
`define PC4 5'h10
`define PC5 5'h11
`define PD0 5'h12
`define PD1 5'h13
`define PE0 5'h14
`define PE1 5'h15
`define PE2 5'h16
`define PE3 5'h17
`define PE7 5'h18
`define PH0 5'h19
`define PH1 5'h1A
`define PH2 5'h1B

// ************************************************************
// Function indices, lower index wins a shared pin
// ************************************************************
`define F_T2C3  0
`define F_T2C2  1
`define F_T2C1  2
`define F_T2C0  3
`define F_T1C1  4
`define F_T1C0  5
`define F_T0C1  6
`define F_T0C0  7
`define F_URX   8
`define F_UTX   9
`define F_SCK   10
`define F_MOSI  11
`define F_MISO  12
`define F_PCS   13
`define F_SCL   14
`define F_SDA   15
`define F_CNT   16

`endif

// File: logic/pin_route_pkg.sv
// Types shared by the pin routing block.
// Assumes pin_route_defines.svh is on the include path.
`include "pin_route_defines.svh"

package pin_route_pkg;
  typedef logic [`PIN_N-1:0]  pin_vec_t;
  typedef logic [`FN_N-1:0]   fn_vec_t;
  typedef logic [`IDX_W-1:0]  pin_idx_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`DATA_W-1:0] data_t;
endpackage

// File: logic/pin_sync.sv
// Two-flop synchroniser for the package pin input levels.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "pin_route_defines.svh"

module pin_sync (
  input  wire logic                ref_clk_i,
  input  wire logic                sys_rst_i,
  input  wire pin_route_pkg::pin_vec_t async_i,
  output var  pin_route_pkg::pin_vec_t sync_o
);

  pin_route_pkg::pin_vec_t meta;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule
`default_nettype wire

// File: logic/peripheral_pin_route_select.sv
// Peripheral pin routing: select and options registers, pin steering.
// Assumes a single 25 MHz clock and a register master on the same clock.
//
// Function
// R1: Pin enable changes only on power-on reset; code also loads it on the first options write after any reset
// R2: Pin enable turns on the shared pull-up
// R3: Enable clear: port roles; set: interrupt input
// R4: Reserved bits ignore writes, read zero
// R5: Select register decodes at offset 8h
// R6: Bit 15 steers timer2 channel3 pins
// R7: Bit 14 steers timer2 channel2 pins
// R8: Bit 13 steers timer2 channel1 pins
// R9: Bit 12 steers timer2 channel0 pins
// R10: Bit 11 steers timer1 channel1 pins
// R11: Bit 10 steers timer1 channel0 pins
// R12: Bit 9 steers timer0 channel1 pins
// R13: Bit 8 steers timer0 channel0 pins
// R14: Bit 7 steers first UART pins
// R15: Bit 6 steers first SPI pins
// R16: Bit 5 steers first I2C pins
// R17: Bit 4 steers counter output pin
// R18: Select bits hold, read back, steer immediately
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pin_route_defines.svh"

module peripheral_pin_route_select (
  input  wire logic                    ref_clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    por_rst_i,
  input  wire pin_route_pkg::addr_t    addr_i,
  input  wire pin_route_pkg::data_t    wr_data_i,
  input  wire logic                    wr_en_i,
  input  wire logic                    rd_en_i,
  output var  pin_route_pkg::data_t    rd_data_o,
  input  wire pin_route_pkg::fn_vec_t  fn_out_i,
  input  wire pin_route_pkg::fn_vec_t  fn_oe_i,
  output var  pin_route_pkg::fn_vec_t  fn_in_o,
  input  wire pin_route_pkg::pin_vec_t gpio_out_i,
  input  wire pin_route_pkg::pin_vec_t gpio_oe_i,
  output var  pin_route_pkg::pin_vec_t gpio_in_o,
  input  wire pin_route_pkg::pin_vec_t pin_in_i,
  output var  pin_route_pkg::pin_vec_t pin_out_o,
  output var  pin_route_pkg::pin_vec_t pin_oe_o,
  output var  logic                    nmi_pullup_o,
  output var  logic                    nmi_in_o,
  output var  logic                    timer2_channel4_in_o,
  output var  logic                    comparator1_input2_o
);

  // ************************************************************
  // Route tables
  // ************************************************************
  localparam int unsigned SEL_BIT [`FN_N] = '{
    `T2C3_SEL, `T2C2_SEL, `T2C1_SEL, `T2C0_SEL,
    `T1C1_SEL, `T1C0_SEL, `T0C1_SEL, `T0C0_SEL,
    `UART_SEL, `UART_SEL,
    `SPI_SEL, `SPI_SEL, `SPI_SEL, `SPI_SEL,
    `I2C_SEL, `I2C_SEL, `CNT_SEL};

  localparam pin_route_pkg::pin_idx_t PIN_A [`FN_N] = '{
    `PC3, `PC2, `PC1, `PC0,
    `PC5, `PC4, `PA1, `PA0,
    `PB0, `PB1,
    `PB2, `PB3, `PB4, `PB5,
    `PA3, `PA2, `PC4};

  localparam pin_route_pkg::pin_idx_t PIN_B [`FN_N] = '{
    `PD1, `PD0, `PH1, `PH0,
    `PE7, `PH2, `PB3, `PB2,
    `PA2, `PA3,
    `PE0, `PE1, `PE2, `PE3,
    `PB7, `PB6, `PC5};

  localparam int SEL_W = `SEL_TOP + 1;

  // ************************************************************
  // Registers
  // ************************************************************
  logic [`SEL_TOP:0]       pin_route_select;
  logic                    interrupt_pin_enable;
  logic                    options_written;
  pin_route_pkg::pin_vec_t pin_sync_q;
  pin_route_pkg::data_t    next_rd_data;

  logic sel_hit;
  logic opt_hit;

  assign sel_hit = (addr_i == `SEL_OFFSET); // [R5]
  assign opt_hit = (addr_i == `OPT_OFFSET);

  // Select register, reserved bits dropped on write
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pin_route_select <= `SEL_RESET;
    end else if (wr_en_i && sel_hit) begin
      // [R4] [R18]
      pin_route_select <= SEL_W'(wr_data_i & `SEL_WR_MASK);
    end
  end

  // Enable bit: preset by power-on reset only, write-once after any reset
  always_ff @(posedge ref_clk_i) begin
    if (por_rst_i) begin
      interrupt_pin_enable <= `IPE_POR_VALUE; // [R1]
    end else if (!sys_rst_i && wr_en_i && opt_hit && !options_written) begin
      interrupt_pin_enable <= wr_data_i[`IPE_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || por_rst_i) begin
      options_written <= 1'b0;
    end else if (wr_en_i && opt_hit) begin
      options_written <= 1'b1;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_comb begin
    next_rd_data = '0;
    if (sel_hit) begin
      next_rd_data[`SEL_TOP:0] = pin_route_select; // [R4] [R18]
    end else if (opt_hit) begin
      next_rd_data[`IPE_BIT] = interrupt_pin_enable; // [R4]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= '0;
    end else if (rd_en_i) begin
      rd_data_o <= next_rd_data;
    end else begin
      rd_data_o <= '0;
    end
  end

  // ************************************************************
  // Pin input synchroniser
  // ************************************************************
  pin_sync u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (pin_in_i),
    .sync_o    (pin_sync_q)
  );

  assign gpio_in_o = pin_sync_q;

  // ************************************************************
  // Function steering
  // ************************************************************
  pin_route_pkg::pin_idx_t chosen [`FN_N];

  // [R6] [R7] [R8] [R9] [R10] [R11] [R12] [R13]
  // [R14] [R15] [R16] [R17] [R18]
  for (genvar f = 0; f < `FN_N; f++) begin : g_fn
    assign chosen[f] = pin_route_select[SEL_BIT[f]] ? PIN_B[f] : PIN_A[f];

    // Data-in reads zero while the shared pin is the interrupt input, on either route
    if (f == `F_MISO) begin : g_miso
      assign fn_in_o[f] = interrupt_pin_enable ? 1'b0
                                               : pin_sync_q[chosen[f]]; // [R3]
    end else begin : g_plain
      assign fn_in_o[f] = pin_sync_q[chosen[f]];
    end
  end

  // ************************************************************
  // Pin drivers
  // ************************************************************
  for (genvar p = 0; p < `PIN_N; p++) begin : g_pin
    logic owned;
    logic own_out;
    logic own_oe;

    // Lowest function index wins a pin shared by two routes
    always_comb begin
      owned   = 1'b0;
      own_out = 1'b0;
      own_oe  = 1'b0;
      for (int f = `FN_N - 1; f >= 0; f--) begin
        if (chosen[f] == `IDX_W'(p)) begin
          owned   = 1'b1;
          own_out = fn_out_i[f];
          own_oe  = fn_oe_i[f];
        end
      end
    end

    if (p == `PB4) begin : g_shared
      // [R3]
      assign pin_out_o[p] = interrupt_pin_enable ? 1'b0
                          : (owned ? own_out : gpio_out_i[p]);
      assign pin_oe_o[p]  = interrupt_pin_enable ? 1'b0
                          : (owned ? own_oe : gpio_oe_i[p]);
    end else begin : g_normal
      assign pin_out_o[p] = owned ? own_out : gpio_out_i[p];
      assign pin_oe_o[p]  = owned ? own_oe : gpio_oe_i[p];
    end
  end

  // ************************************************************
  // Interrupt input pin
  // ************************************************************
  assign nmi_pullup_o         = interrupt_pin_enable; // [R2]
  // Active-low input idles high while the pin serves other roles
  assign nmi_in_o             = interrupt_pin_enable ? pin_sync_q[`PB4]
                                                     : 1'b1; // [R3]
  assign timer2_channel4_in_o = interrupt_pin_enable ? 1'b0
                                                     : pin_sync_q[`PB4];
  assign comparator1_input2_o = interrupt_pin_enable ? 1'b0
                                                     : pin_sync_q[`PB4];

  // ************************************************************
  // Assertions
  // ************************************************************
  ipe_por_set_a: assert property ( // [R1]
    @(posedge ref_clk_i) por_rst_i |=> interrupt_pin_enable)
    else $error("enable not set by power-on reset");

  ipe_warm_hold_a: assert property ( // [R1]
    @(posedge ref_clk_i) disable iff (por_rst_i)
    sys_rst_i |=> interrupt_pin_enable == $past(interrupt_pin_enable))
    else $error("enable changed by non power-on reset");

  ipe_once_a: assert property ( // [R1]
    @(posedge ref_clk_i) disable iff (sys_rst_i || por_rst_i)
    options_written && !$rose(options_written) |=> $stable(interrupt_pin_enable))
    else $error("enable changed after first write");

  pullup_role_a: assert property ( // [R2]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    nmi_pullup_o |-> !pin_oe_o[`PB4] && !fn_in_o[`F_MISO])
    else $error("shared pin driven while pulled up");

  shared_port_a: assert property ( // [R3]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !interrupt_pin_enable && !pin_route_select[`SPI_SEL]
    |-> pin_oe_o[`PB4] == fn_oe_i[`F_MISO] && nmi_in_o)
    else $error("shared pin not in port role");

  rsvd_read_a: assert property ( // [R4]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    rd_en_i && sel_hit |=> rd_data_o[`DATA_W-1:`SEL_TOP+1] == '0
      && rd_data_o[`CNT_SEL-1:0] == '0)
    else $error("reserved bits read nonzero");

  opt_rsvd_a: assert property ( // [R4]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    rd_en_i && opt_hit |=> rd_data_o[`DATA_W-1:`IPE_BIT+1] == '0
      && !rd_data_o[`IPE_BIT-1])
    else $error("options reserved bits read nonzero");

  sel_readback_a: assert property ( // [R5]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    wr_en_i && sel_hit ##1 rd_en_i && sel_hit && !wr_en_i
    |=> rd_data_o == (`DATA_W'($past(wr_data_i, 2)) & `SEL_WR_MASK))
    else $error("select register readback mismatch");

  sel_write_a: assert property ( // [R18]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    wr_en_i && sel_hit |=> pin_route_select[`T2C3_SEL]
      == $past(wr_data_i[`T2C3_SEL]))
    else $error("select bit not stored");

  t2c3_route_a: assert property ( // [R6]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    pin_route_select[`T2C3_SEL]
    |-> pin_out_o[`PD1] == fn_out_i[`F_T2C3]
      && pin_oe_o[`PD1] == fn_oe_i[`F_T2C3]
      && pin_oe_o[`PC3] == gpio_oe_i[`PC3])
    else $error("timer2 channel3 on wrong pin");

  t2c2_route_a: assert property ( // [R7]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    pin_route_select[`T2C2_SEL]
    |-> pin_out_o[`PD0] == fn_out_i[`F_T2C2]
      && pin_oe_o[`PD0] == fn_oe_i[`F_T2C2]
      && pin_oe_o[`PC2] == gpio_oe_i[`PC2])
    else $error("timer2 channel2 on wrong pin");

  t2c1_route_a: assert property ( // [R8]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    pin_route_select[`T2C1_SEL]
    |-> pin_out_o[`PH1] == fn_out_i[`F_T2C1]
      && pin_oe_o[`PH1] == fn_oe_i[`F_T2C1]
      && pin_oe_o[`PC1] == gpio_oe_i[`PC1])
    else $error("timer2 channel1 on wrong pin");

  t2c0_route_a: assert property ( // [R9]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    pin_route_select[`T2C0_SEL]
    |-> pin_out_o[`PH0] == fn_out_i[`F_T2C0]
      && pin_oe_o[`PH0] == fn_oe_i[`F_T2C0]
      && pin_oe_o[`PC0] == gpio_oe_i[`PC0])
    else $error("timer2 channel0 on wrong pin");

  t1c1_route_a: assert property ( // [R10]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    pin_route_select[`T1C1_SEL]
    |-> pin_out_o[`PE7] == fn_out_i[`F_T1C1]
      && pin_oe_o[`PE7] == fn_oe_i[`F_T1C1])
    else $error("timer1 channel1 on wrong pin");

  t1c0_route_a: assert property ( // [R11]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    pin_route_select[`T1C0_SEL]
    |-> pin_out_o[`PH2] == fn_out_i[`F_T1C0]
      && pin_oe_o[`PH2] == fn_oe_i[`F_T1C0])
    else $error("timer1 channel0 on wrong pin");

  t0c1_route_a: assert property ( // [R12]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    pin_route_select[`T0C1_SEL]
    |-> pin_out_o[`PB3] == fn_out_i[`F_T0C1]
      && pin_oe_o[`PB3] == fn_oe_i[`F_T0C1]
      && pin_oe_o[`PA1] == gpio_oe_i[`PA1])
    else $error("timer0 channel1 on wrong pin");

  t0c0_route_a: assert property ( // [R13]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    pin_route_select[`T0C0_SEL]
    |-> pin_out_o[`PB2] == fn_out_i[`F_T0C0]
      && pin_oe_o[`PB2] == fn_oe_i[`F_T0C0]
      && pin_oe_o[`PA0] == gpio_oe_i[`PA0])
    else $error("timer0 channel0 on wrong pin");

  uart_route_a: assert property ( // [R14]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    pin_route_select[`UART_SEL]
    |-> pin_out_o[`PA2] == fn_out_i[`F_URX]
      && pin_out_o[`PA3] == fn_out_i[`F_UTX]
      && pin_oe_o[`PB0] == gpio_oe_i[`PB0])
    else $error("first UART on wrong pins");

  i2c_route_a: assert property ( // [R16]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    pin_route_select[`I2C_SEL]
    |-> pin_out_o[`PB7] == fn_out_i[`F_SCL]
      && pin_out_o[`PB6] == fn_out_i[`F_SDA]
      && pin_oe_o[`PB6] == fn_oe_i[`F_SDA])
    else $error("first I2C on wrong pins");

  spi_route_a: assert property ( // [R15]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    pin_route_select[`SPI_SEL]
    |-> pin_out_o[`PE0] == fn_out_i[`F_SCK]
      && pin_out_o[`PE1] == fn_out_i[`F_MOSI]
      && pin_oe_o[`PE3] == fn_oe_i[`F_PCS])
    else $error("first SPI on wrong pins");

  counter_route_a: assert property ( // [R17]
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !pin_route_select[`CNT_SEL] && pin_route_select[`T1C0_SEL]
    |-> pin_out_o[`PC4] == fn_out_i[`F_CNT])
    else $error("counter output on wrong pin");

endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the peripheral pin routing block.
// Assumes the design files under logic/ and the shared defines header.
`timescale 1ns/1ps
`default_nettype none
`include "pin_route_defines.svh"

module testbench;
  // ************************************************************
  // Stimulus and design
  // ************************************************************
  logic                     ref_clk_i  = 1'b0;
  logic                     sys_rst_i  = 1'b1;
  logic                     por_rst_i  = 1'b1;
  pin_route_pkg::addr_t     addr_i     = '0;
  pin_route_pkg::data_t     wr_data_i  = '0;
  logic                     wr_en_i    = 1'b0;
  logic                     rd_en_i    = 1'b0;
  pin_route_pkg::fn_vec_t   fn_out_i   = '0;
  pin_route_pkg::fn_vec_t   fn_oe_i    = '0;
  pin_route_pkg::pin_vec_t  gpio_out_i = '0;
  pin_route_pkg::pin_vec_t  gpio_oe_i  = '0;
  pin_route_pkg::pin_vec_t  pin_in_i   = '0;
  pin_route_pkg::data_t     rd_data_o;
  pin_route_pkg::fn_vec_t   fn_in_o;
  pin_route_pkg::pin_vec_t  gpio_in_o;
  pin_route_pkg::pin_vec_t  pin_out_o;
  pin_route_pkg::pin_vec_t  pin_oe_o;
  logic                     nmi_pullup_o;
  logic                     nmi_in_o;
  logic                     timer2_channel4_in_o;
  logic                     comparator1_input2_o;
  int                       num_errors = 0;
  int                       n_compared = 0;

  // Select bit and pins (select 0 / 1) per function index
  localparam int SB[17] = '{15, 14, 13, 12, 11, 10, 9, 8, 7, 7, 6, 6, 6, 6,
                            5, 5, 4};
  localparam int P0[17] = '{15, 14, 13, 12, 17, 16, 1, 0, 4, 5, 6, 7, 8, 9,
                            3, 2, 16};
  localparam int P1[17] = '{19, 18, 26, 25, 24, 27, 7, 6, 2, 3, 20, 21, 22,
                            23, 11, 10, 17};

  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  peripheral_pin_route_select u_dut (
    .ref_clk_i            (ref_clk_i),
    .sys_rst_i            (sys_rst_i),
    .por_rst_i            (por_rst_i),
    .addr_i               (addr_i),
    .wr_data_i            (wr_data_i),
    .wr_en_i              (wr_en_i),
    .rd_en_i              (rd_en_i),
    .rd_data_o            (rd_data_o),
    .fn_out_i             (fn_out_i),
    .fn_oe_i              (fn_oe_i),
    .fn_in_o              (fn_in_o),
    .gpio_out_i           (gpio_out_i),
    .gpio_oe_i            (gpio_oe_i),
    .gpio_in_o            (gpio_in_o),
    .pin_in_i             (pin_in_i),
    .pin_out_o            (pin_out_o),
    .pin_oe_o             (pin_oe_o),
    .nmi_pullup_o         (nmi_pullup_o),
    .nmi_in_o             (nmi_in_o),
    .timer2_channel4_in_o (timer2_channel4_in_o),
    .comparator1_input2_o (comparator1_input2_o)
  );

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_en_i   <= 1'b1;
    addr_i    <= a;
    wr_data_i <= d;
    @(posedge ref_clk_i);
    wr_en_i   <= 1'b0;
    #1;
  endtask

  // Read data stand one cycle, then return to zero
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    rd_en_i <= 1'b1;
    addr_i  <= a;
    @(posedge ref_clk_i);
    rd_en_i <= 1'b0;
    #1;
    chk(rd_data_o, exp, "read data");
    @(posedge ref_clk_i);
    #1;
    chk(rd_data_o, 32'h0000_0000, "read data after slot");
  endtask

  // Write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp);
    @(posedge ref_clk_i);
    wr_en_i   <= 1'b1;
    addr_i    <= a;
    wr_data_i <= d;
    @(posedge ref_clk_i);
    wr_en_i   <= 1'b0;
    rd_en_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_en_i   <= 1'b0;
    #1;
    chk(rd_data_o, exp, "back-to-back read");
  endtask

  task automatic pulse(input logic por);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    por_rst_i <= por;
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    por_rst_i <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask

  // One function on one select value: drive, read back, pin sense
  task automatic route_case(input int f, input logic s);
    pin_route_pkg::pin_vec_t pv;
    pin_route_pkg::fn_vec_t  fv;
    logic [31:0]             sel;
    pv       = '0;
    pv[s ? P1[f] : P0[f]] = 1'b1;
    fv       = '0;
    fv[f]    = 1'b1;
    sel      = 32'(s) << SB[f];
    // Timer1 leaves the counter's pin, else its lower index wins it
    if (f == 16) begin
      sel = sel | (32'h0000_0400 << s);
    end
    @(posedge ref_clk_i);
    fn_oe_i  <= fv;
    fn_out_i <= fv;
    pin_in_i <= pv;
    wr(8'h08, sel);
    chk({4'h0, pin_oe_o}, {4'h0, pv}, "pin enable");
    chk({4'h0, pin_out_o}, {4'h0, pv}, "pin drive");
    rd(8'h08, sel);
    chk({31'h0, fn_in_o[f]}, 32'h0000_0001, "function input");
    chk({4'h0, gpio_in_o}, {4'h0, pv}, "pin sense");
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (10) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    por_rst_i <= 1'b0;
    rd(8'h08, 32'h0000_0000);
    rd(`OPT_OFFSET, 32'h0000_0002);
    chk({31'h0, nmi_pullup_o}, 32'h0000_0001, "pull-up on");
    gpio_oe_i <= '1;
    gpio_out_i <= '1;
    fn_oe_i <= '1;
    fn_out_i <= '1;
    settle();
    chk({31'h0, pin_oe_o[8]}, 32'h0000_0000, "shared pin driven");
    chk({31'h0, pin_out_o[8]}, 32'h0000_0000, "shared pin level");
    chk({31'h0, nmi_in_o}, 32'h0000_0000, "interrupt input");
    chk({31'h0, timer2_channel4_in_o}, 32'h0000_0000, "timer in");
    chk({31'h0, comparator1_input2_o}, 32'h0000_0000, "cmp in");
    pin_in_i <= 28'h000_0100;
    settle();
    chk({31'h0, nmi_in_o}, 32'h0000_0001, "interrupt level");
    chk({31'h0, timer2_channel4_in_o}, 32'h0000_0000, "timer masked");
    chk({31'h0, comparator1_input2_o}, 32'h0000_0000, "cmp masked");
    $display("Test reset_state done");

    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h08, 32'h0000_FFF0);
    wr(8'h0C, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h08, 32'h0000_FFF0);
    wr_rd(8'h08, 32'h1234_5678, 32'h0000_5670);
    wr(`OPT_OFFSET, 32'hFFFF_FFFF);
    rd(`OPT_OFFSET, 32'h0000_0002);
    pulse(1'b0);
    rd(`OPT_OFFSET, 32'h0000_0002);
    rd(8'h08, 32'h0000_0000);
    wr(`OPT_OFFSET, 32'h0000_0000);
    rd(`OPT_OFFSET, 32'h0000_0000);
    chk({31'h0, nmi_pullup_o}, 32'h0000_0000, "pull-up off");
    wr(`OPT_OFFSET, 32'h0000_0002);
    rd(`OPT_OFFSET, 32'h0000_0000);
    pulse(1'b0);
    rd(`OPT_OFFSET, 32'h0000_0000);
    pin_in_i <= 28'h000_0100;
    settle();
    chk({31'h0, pin_oe_o[8]}, 32'h0000_0001, "shared pin port");
    chk({31'h0, pin_out_o[8]}, 32'h0000_0001, "shared pin out");
    chk({31'h0, timer2_channel4_in_o}, 32'h0000_0001, "timer in");
    chk({31'h0, comparator1_input2_o}, 32'h0000_0001, "cmp in");
    chk({31'h0, nmi_in_o}, 32'h0000_0001, "interrupt idle");
    $display("Test registers done");

    gpio_oe_i  <= '0;
    gpio_out_i <= '0;
    for (int f = 0; f < 8; f++) begin
      for (int s = 0; s < 2; s++) begin
        route_case(f, s[0]);
      end
    end
    for (int f = 8; f < 17; f++) begin
      for (int s = 0; s < 2; s++) begin
        route_case(f, s[0]);
      end
    end
    $display("Test routing done");

    pulse(1'b1);
    rd(`OPT_OFFSET, 32'h0000_0002);
    chk({31'h0, nmi_pullup_o}, 32'h0000_0001, "pull-up after por");
    $display("Test power_on done");
    summarize();
  end
endmodule
`default_nettype wire
